// *** include/ctmc_pkg.sv ***
// Functional notes
// - Mode field bits 26:24; 000 is timer
// - Capture mode 010 copies count on capture
// - Mode 011 is quadrature; the core holds the count there
// - Modes 100, 101, 110 are PWM variants; the count holds
// - Timer steps by one per detected count
// - Direction field 17:16; up raises TC at period
// - Down counts from period, TC at zero
// - Up/down 0: TC only at zero
// - Up/down 1: TC at zero and period
// - Up counting reloads zero after period
// - Down counting reloads period after zero
// - Up/down modes reverse without reload
// - Cycle is A+1 steps, 2*A up/down
// - Match event; optional compare/buffer swap
// - One-shot bit 18 stops after terminal count
// - Eight-bit prescaler divides counter clock
// - Period, compare, buffer are 16 bits
// - Selectable trigger sources and active edges
// - Overflow/underflow pulses last two cycles
// - Triggers synchronised before use
// - Request bits latch; write one clears; masked AND
// - Output actions per event, reset to no change
package ctmc_pkg;

    // ==========================================================
    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_PERIOD = 8'h10;
    localparam logic [7:0] ADDR_COMPARE = 8'h14;
    localparam logic [7:0] ADDR_CBUF = 8'h18;
    localparam logic [7:0] ADDR_TSEL = 8'h1c;
    localparam logic [7:0] ADDR_TEDGE = 8'h20;
    localparam logic [7:0] ADDR_OACT = 8'h24;
    localparam logic [7:0] ADDR_IRQ = 8'h28;
    localparam logic [7:0] ADDR_IRQ_SET = 8'h2c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASKED = 8'h34;
    localparam logic [7:0] ADDR_STATUS = 8'h38;

    // ==========================================================
    // Field positions.
    localparam int MODE_LSB = 24;
    localparam int ONE_SHOT_BIT = 18;
    localparam int DIR_LSB = 16;
    localparam int PRESCALE_LSB = 8;
    localparam int SWAP_BIT = 0;
    localparam int CMD_RELOAD = 0;
    localparam int CMD_START = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_CAPTURE = 3;
    localparam int IRQ_TC = 0;
    localparam int IRQ_MATCH = 1;

    // ==========================================================
    // Trigger slots: four select bits and two edge bits each.
    localparam int TRG_RELOAD = 0;
    localparam int TRG_START = 1;
    localparam int TRG_STOP = 2;
    localparam int TRG_CAPTURE = 3;
    localparam int TRG_COUNT = 4;
    localparam int TRG_NUM = 5;
    localparam int TSEL_W = 4;
    localparam int TEDGE_W = 2;

    // ==========================================================
    // Codes.
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_CAPTURE = 3'h2;
    localparam logic [2:0] MODE_QUAD = 3'h3;
    localparam logic [2:0] MODE_PWM = 3'h4;
    localparam logic [2:0] MODE_DEAD_TIME_PWM = 3'h5;
    localparam logic [2:0] MODE_PSEUDO_RANDOM_PWM = 3'h6;
    localparam logic [1:0] DIR_UP = 2'h0;
    localparam logic [1:0] DIR_DOWN = 2'h1;
    localparam logic [1:0] DIR_UPDN0 = 2'h2;
    localparam logic [1:0] DIR_UPDN1 = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_NONE = 2'h3;
    localparam logic [1:0] ACT_SET = 2'h0;
    localparam logic [1:0] ACT_CLR = 2'h1;
    localparam logic [1:0] ACT_INV = 2'h2;
    localparam logic [1:0] ACT_KEEP = 2'h3;

    // ==========================================================
    // Values after reset.
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [19:0] TSEL_RESET = 20'h00000;
    localparam logic [9:0] TEDGE_RESET = 10'h000;
    localparam logic [5:0] OACT_RESET = 6'h3f;

endpackage : ctmc_pkg

// *** hdl/ctmc_core.sv ***
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ctmc_core #(
    parameter int N_TRIG = 8
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic ARST_N,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:31-31] HRDATA,
    // Trigger sources.
    input wire logic [N_TRIG-1:0] TRIG_IN,
    // Event and line outputs.
    output logic TERMINAL_COUNT,
    output logic OVERFLOW_EVENT,
    output logic UNDERFLOW_EVENT,
    output logic MATCH_CAPTURE_EVENT,
    output logic LINE_OUT,
    output logic LINE_COMPL_OUT
);

    // ==========================================================
    // State.
    typedef struct packed {
        logic [2:0] mode;
        logic one_shot;
        logic [1:0] dir;
        logic [7:0] prescale;
        logic swap_en;
        logic enable;
        logic [15:0] count;
        logic [15:0] period;
        logic [15:0] compare;
        logic [15:0] cbuf;
        logic [19:0] tsel;
        logic [9:0] tedge;
        logic [5:0] oact;
        logic [1:0] irq;
        logic [1:0] mask;
        logic running;
        logic down;
        logic [7:0] pre_cnt;
        logic cnt_pend;
        logic [N_TRIG-1:0] sync1;
        logic [N_TRIG-1:0] sync2;
        logic [N_TRIG-1:0] sync3;
        logic a_valid;
        logic a_write;
        logic [7:0] a_addr;
        logic [31:0] rdata;
        logic tc_last;
        logic ov_last;
        logic un_last;
        logic cc_last;
        logic tc_o;
        logic ov_o;
        logic un_o;
        logic cc_o;
        logic line;
        // Complement kept in its own flop so both line pins leave a register.
        logic line_n;
    } ctmc_state_s;

    ctmc_state_s s;
    ctmc_state_s next_s;

    logic [ctmc_pkg::TRG_NUM-1:0] hit;
    logic [3:0] cmd;
    logic [1:0] irq_clr;
    logic [1:0] irq_sw_set;
    logic wr;
    logic tick;
    logic active;
    logic count_ok;
    logic [15:0] nxt;
    logic tc_ev;
    logic ov_ev;
    logic un_ev;
    logic cc_ev;
    logic cap_ev;

    // ==========================================================
    // Edge detection of one selected, synchronised trigger.
    // Select code 0 means no source; code k picks input k-1.
    function automatic logic trig_hit(input logic [3:0] sel, input logic [1:0] edg,
                                      input logic [N_TRIG-1:0] now,
                                      input logic [N_TRIG-1:0] old);
        logic n;
        logic o;
        n = 1'b0;
        o = 1'b0;
        if (sel != 4'h0 && int'(sel) <= N_TRIG) begin
            n = now[int'(sel) - 1];
            o = old[int'(sel) - 1];
        end
        unique case (edg)
            ctmc_pkg::EDGE_RISE: trig_hit = n & ~o;
            ctmc_pkg::EDGE_FALL: trig_hit = ~n & o;
            ctmc_pkg::EDGE_BOTH: trig_hit = n ^ o;
            ctmc_pkg::EDGE_NONE: trig_hit = 1'b0;
        endcase
    endfunction : trig_hit

    // ==========================================================
    // One output action applied to the line level.
    function automatic logic line_act(input logic [1:0] act, input logic ev, input logic l);
        line_act = l;
        if (ev) begin
            unique case (act)
                ctmc_pkg::ACT_SET: line_act = 1'b1;
                ctmc_pkg::ACT_CLR: line_act = 1'b0;
                ctmc_pkg::ACT_INV: line_act = ~l;
                ctmc_pkg::ACT_KEEP: line_act = l;
            endcase
        end
    endfunction : line_act

    // ==========================================================
    // Next-state logic for the whole channel.
    always_comb begin
        next_s = s;
        hit = '0;
        cmd = 4'h0;
        irq_clr = 2'h0;
        irq_sw_set = 2'h0;
        nxt = s.count;
        tc_ev = 1'b0;
        ov_ev = 1'b0;
        un_ev = 1'b0;
        cc_ev = 1'b0;
        cap_ev = 1'b0;

        // Two-flop synchroniser; the third stage only serves edge detection.
        next_s.sync1 = TRIG_IN;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        for (int i = 0; i < ctmc_pkg::TRG_NUM; i++) begin
            hit[i] = trig_hit(s.tsel[i*ctmc_pkg::TSEL_W +: ctmc_pkg::TSEL_W],
                              s.tedge[i*ctmc_pkg::TEDGE_W +: ctmc_pkg::TEDGE_W],
                              s.sync2, s.sync3);
        end

        // Command pulses and interrupt clears come from the write data phase.
        wr = s.a_valid & s.a_write;
        if (wr && s.a_addr == ctmc_pkg::ADDR_CMD) begin
            cmd = HWDATA[3:0];
        end
        if (wr && s.a_addr == ctmc_pkg::ADDR_IRQ) begin
            irq_clr = HWDATA[1:0];
        end
        if (wr && s.a_addr == ctmc_pkg::ADDR_IRQ_SET) begin
            irq_sw_set = HWDATA[1:0];
        end

        // Prescaler: one counter tick every prescale+1 clocks.
        // Count events closer together than one tick merge into a single step,
        // so a slow counter clock can miss fast triggers.
        tick = (s.pre_cnt == s.prescale);
        next_s.pre_cnt = tick ? 8'h00 : s.pre_cnt + 8'h01;

        // A count trigger that falls between ticks waits for the next tick.
        next_s.cnt_pend = tick ? 1'b0 : (s.cnt_pend | hit[ctmc_pkg::TRG_COUNT]);
        count_ok = (s.tsel[ctmc_pkg::TRG_COUNT*ctmc_pkg::TSEL_W +: ctmc_pkg::TSEL_W] == 4'h0)
                   | s.cnt_pend | hit[ctmc_pkg::TRG_COUNT];

        // Only timer and capture count here; quadrature and PWM codes hold.
        active = s.enable & s.running &
                 (s.mode == ctmc_pkg::MODE_TIMER || s.mode == ctmc_pkg::MODE_CAPTURE);

        // Start and stop; without a hardware start, a software start is needed.
        if (hit[ctmc_pkg::TRG_STOP] | cmd[ctmc_pkg::CMD_STOP]) begin
            next_s.running = 1'b0;
        end else if (hit[ctmc_pkg::TRG_START] | cmd[ctmc_pkg::CMD_START]) begin
            next_s.running = 1'b1;
        end

        // Reload puts the counter at its starting end and direction.
        if (hit[ctmc_pkg::TRG_RELOAD] | cmd[ctmc_pkg::CMD_RELOAD]) begin
            next_s.count = (s.dir == ctmc_pkg::DIR_DOWN) ? s.period : 16'h0000;
            next_s.down = (s.dir == ctmc_pkg::DIR_DOWN);
        end else if (tick && active && count_ok) begin
            // One step per tick with a count event; otherwise the value holds.
            unique case (s.dir)
                ctmc_pkg::DIR_UP: begin
                    nxt = (s.count == s.period) ? 16'h0000 : s.count + 16'h0001;
                    ov_ev = (nxt == s.period);
                    tc_ev = ov_ev;
                end
                ctmc_pkg::DIR_DOWN: begin
                    nxt = (s.count == 16'h0000) ? s.period : s.count - 16'h0001;
                    un_ev = (nxt == 16'h0000);
                    tc_ev = un_ev;
                end
                ctmc_pkg::DIR_UPDN0, ctmc_pkg::DIR_UPDN1: begin
                    // Turn around at the ends, so a period A spans 2*A steps.
                    nxt = s.down ? s.count - 16'h0001 : s.count + 16'h0001;
                    if (!s.down && nxt == s.period) begin
                        next_s.down = 1'b1;
                        ov_ev = 1'b1;
                        tc_ev = (s.dir == ctmc_pkg::DIR_UPDN1);
                    end else if (s.down && nxt == 16'h0000) begin
                        next_s.down = 1'b0;
                        un_ev = 1'b1;
                        tc_ev = 1'b1;
                    end
                end
            endcase
            next_s.count = nxt;
            // Match only in timer mode; capture mode owns the compare register.
            if (s.mode == ctmc_pkg::MODE_TIMER && nxt == s.compare) begin
                cc_ev = 1'b1;
                if (s.swap_en) begin
                    next_s.compare = s.cbuf;
                    next_s.cbuf = s.compare;
                end
            end
            // One-shot stops at the terminal count; continuous keeps going.
            if (tc_ev && s.one_shot) begin
                next_s.running = 1'b0;
            end
        end

        // Capture copies count into compare and compare into the buffer.
        cap_ev = active && s.mode == ctmc_pkg::MODE_CAPTURE &&
                 (hit[ctmc_pkg::TRG_CAPTURE] | cmd[ctmc_pkg::CMD_CAPTURE]);
        if (cap_ev) begin
            next_s.compare = s.count;
            next_s.cbuf = s.compare;
            cc_ev = 1'b1;
        end

        // Register writes; reconfiguring a running channel is not guarded.
        if (wr) begin
            unique case (s.a_addr)
                ctmc_pkg::ADDR_CTRL: begin
                    next_s.mode = HWDATA[ctmc_pkg::MODE_LSB +: 3];
                    next_s.one_shot = HWDATA[ctmc_pkg::ONE_SHOT_BIT];
                    next_s.dir = HWDATA[ctmc_pkg::DIR_LSB +: 2];
                    next_s.prescale = HWDATA[ctmc_pkg::PRESCALE_LSB +: 8];
                    next_s.swap_en = HWDATA[ctmc_pkg::SWAP_BIT];
                end
                ctmc_pkg::ADDR_ENABLE: next_s.enable = HWDATA[0];
                ctmc_pkg::ADDR_COUNT: next_s.count = HWDATA[15:0];
                ctmc_pkg::ADDR_PERIOD: next_s.period = HWDATA[15:0];
                ctmc_pkg::ADDR_COMPARE: next_s.compare = HWDATA[15:0];
                ctmc_pkg::ADDR_CBUF: next_s.cbuf = HWDATA[15:0];
                ctmc_pkg::ADDR_TSEL: next_s.tsel = HWDATA[19:0];
                ctmc_pkg::ADDR_TEDGE: next_s.tedge = HWDATA[9:0];
                ctmc_pkg::ADDR_OACT: next_s.oact = HWDATA[5:0];
                ctmc_pkg::ADDR_IRQ_MASK: next_s.mask = HWDATA[1:0];
                default: ;
            endcase
        end

        // Disabling stops the channel at once; the count is kept.
        if (!next_s.enable) begin
            next_s.running = 1'b0;
        end

        // Request bits: a hardware event in the clearing cycle survives.
        next_s.irq = (s.irq & ~irq_clr) | irq_sw_set |
                     {cc_ev, tc_ev};

        // Each event output is the OR of this and the previous cycle: two clocks high.
        next_s.tc_last = tc_ev;
        next_s.ov_last = ov_ev;
        next_s.un_last = un_ev;
        next_s.cc_last = cc_ev;
        next_s.tc_o = tc_ev | s.tc_last;
        next_s.ov_o = ov_ev | s.ov_last;
        next_s.un_o = un_ev | s.un_last;
        next_s.cc_o = cc_ev | s.cc_last;

        // Output line: match, then overflow, then underflow take effect.
        next_s.line = line_act(s.oact[5:4], un_ev,
                      line_act(s.oact[3:2], ov_ev,
                      line_act(s.oact[1:0], cc_ev, s.line)));
        next_s.line_n = ~next_s.line;

        // Address phase; reads see writes finishing in the same cycle.
        next_s.a_valid = HSEL & HTRANS[1] & HREADY;
        next_s.a_write = HWRITE;
        next_s.a_addr = HADDR[7:0];
        if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
            unique case (HADDR[7:0])
                ctmc_pkg::ADDR_CTRL: next_s.rdata = {5'h00, next_s.mode, 5'h00,
                    next_s.one_shot, next_s.dir, next_s.prescale, 7'h00, next_s.swap_en};
                ctmc_pkg::ADDR_ENABLE: next_s.rdata = {31'h00000000, next_s.enable};
                ctmc_pkg::ADDR_COUNT: next_s.rdata = {16'h0000, next_s.count};
                ctmc_pkg::ADDR_PERIOD: next_s.rdata = {16'h0000, next_s.period};
                ctmc_pkg::ADDR_COMPARE: next_s.rdata = {16'h0000, next_s.compare};
                ctmc_pkg::ADDR_CBUF: next_s.rdata = {16'h0000, next_s.cbuf};
                ctmc_pkg::ADDR_TSEL: next_s.rdata = {12'h000, next_s.tsel};
                ctmc_pkg::ADDR_TEDGE: next_s.rdata = {22'h000000, next_s.tedge};
                ctmc_pkg::ADDR_OACT: next_s.rdata = {26'h0000000, next_s.oact};
                ctmc_pkg::ADDR_IRQ, ctmc_pkg::ADDR_IRQ_SET:
                    next_s.rdata = {30'h00000000, next_s.irq};
                ctmc_pkg::ADDR_IRQ_MASK: next_s.rdata = {30'h00000000, next_s.mask};
                ctmc_pkg::ADDR_IRQ_MASKED:
                    next_s.rdata = {30'h00000000, next_s.irq & next_s.mask};
                ctmc_pkg::ADDR_STATUS:
                    next_s.rdata = {30'h00000000, next_s.down, next_s.running};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // State register; every control field has a constant reset value.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s <= '0;
            s.period <= ctmc_pkg::PERIOD_RESET;
            s.tsel <= ctmc_pkg::TSEL_RESET;
            s.tedge <= ctmc_pkg::TEDGE_RESET;
            s.oact <= ctmc_pkg::OACT_RESET;
            s.line_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Data and event outputs straight from flops, ready and response tied off; the slave never stretches a transfer.
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = s.rdata;
    assign TERMINAL_COUNT = s.tc_o;
    assign OVERFLOW_EVENT = s.ov_o;
    assign UNDERFLOW_EVENT = s.un_o;
    assign MATCH_CAPTURE_EVENT = s.cc_o;
    assign LINE_OUT = s.line;
    assign LINE_COMPL_OUT = s.line_n;

endmodule : ctmc_core

`default_nettype wire

// *** tb/ctmc_core_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker; a shadow of the written settings gives context.
module ctmc_checker (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic ARST_N,
    // Bus request side.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    // Events and line.
    input wire logic TERMINAL_COUNT,
    input wire logic OVERFLOW_EVENT,
    input wire logic UNDERFLOW_EVENT,
    input wire logic MATCH_CAPTURE_EVENT,
    input wire logic LINE_OUT,
    input wire logic LINE_COMPL_OUT
);
    logic wp, en, tc, ov, un;
    logic [7:0] wa;
    logic [31:0] ctl;
    logic [5:0] act;
    logic [2:0] md;
    logic [1:0] dir;
    // Short names keep each property readable.
    assign tc = TERMINAL_COUNT;
    assign ov = OVERFLOW_EVENT;
    assign un = UNDERFLOW_EVENT;
    assign md = ctl[26:24];
    assign dir = ctl[17:16];
    // The shadow updates at the edge ending the data phase, as the slave does.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wp <= 1'b0;
            wa <= 8'h00;
            ctl <= 32'h0;
            en <= 1'b0;
            act <= ctmc_pkg::OACT_RESET;
        end else begin
            wp <= HSEL && HTRANS[1] && HREADY && HWRITE;
            wa <= HADDR[7:0];
            if (wp && wa == ctmc_pkg::ADDR_CTRL) ctl <= HWDATA;
            if (wp && wa == ctmc_pkg::ADDR_ENABLE) en <= HWDATA[0];
            if (wp && wa == ctmc_pkg::ADDR_OACT) act <= HWDATA[5:0];
        end
    end
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);
    chk_ov_pulse: assert property ($rose(ov) |=> ov ##1 !ov)
        else $error("Overflow pulse length wrong.");
    chk_un_pulse: assert property ($rose(un) |=> un ##1 !un)
        else $error("Underflow pulse length wrong.");
    chk_up_tc: assert property (
        md == ctmc_pkg::MODE_TIMER && dir == ctmc_pkg::DIR_UP && $rose(ov) |-> $rose(tc))
        else $error("Up count top without terminal count.");
    chk_down_tc: assert property (
        md == ctmc_pkg::MODE_TIMER && dir == ctmc_pkg::DIR_DOWN && $rose(un) |-> $rose(tc))
        else $error("Down count zero without terminal count.");
    chk_updn0_top: assert property (
        md == ctmc_pkg::MODE_TIMER && dir == ctmc_pkg::DIR_UPDN0 && $rose(ov) |-> !$rose(tc))
        else $error("Terminal count at top in up/down 0.");
    chk_updn1_top: assert property (
        md == ctmc_pkg::MODE_TIMER && dir == ctmc_pkg::DIR_UPDN1 && $rose(ov) |-> $rose(tc))
        else $error("No terminal count at top in up/down 1.");
    chk_idle_quiet: assert property (
        !en && !$past(en) && !$past(en, 2) |-> !$rose(tc) && !$rose(ov) && !$rose(un)
        && !$rose(MATCH_CAPTURE_EVENT))
        else $error("Event from a disabled channel.");
    chk_mode_hold: assert property (
        md == ctmc_pkg::MODE_QUAD && $stable(md) |-> !$rose(ov) && !$rose(tc))
        else $error("Event in a non-counting mode.");
    chk_line_compl: assert property (LINE_COMPL_OUT == !LINE_OUT)
        else $error("Line outputs not complementary.");
    chk_line_keep: assert property (
        act == 6'h3f && $past(act) == 6'h3f |-> $stable(LINE_OUT))
        else $error("Line moved with every action at no change.");
endmodule : ctmc_checker

bind ctmc_core ctmc_checker i_ctmc_checker (
    .MCLK(MCLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .TERMINAL_COUNT(TERMINAL_COUNT),
    .OVERFLOW_EVENT(OVERFLOW_EVENT), .UNDERFLOW_EVENT(UNDERFLOW_EVENT),
    .MATCH_CAPTURE_EVENT(MATCH_CAPTURE_EVENT), .LINE_OUT(LINE_OUT),
    .LINE_COMPL_OUT(LINE_COMPL_OUT)
);
`default_nettype wire

// *** tb/ctmc_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bus-driven bench for one timer channel.
module ctmc_core_tb;
    localparam int A = 4;
    logic MCLK = 1'b0;
    logic ARST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA, q;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [7:0] TRIG_IN;
    logic TC, OV, UN, MC, LO, LC;
    int n_mismatch = 0;
    int check_count = 0;
    int g;
    // ==========================================================
    // Clock, bus ready and the channel.
    always #4 MCLK = ~MCLK;
    assign HREADY = HREADYOUT;
    ctmc_core #(.N_TRIG(8)) i_ctmc_core (
        .MCLK(MCLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .TRIG_IN(TRIG_IN),
        .TERMINAL_COUNT(TC), .OVERFLOW_EVENT(OV), .UNDERFLOW_EVENT(UN),
        .MATCH_CAPTURE_EVENT(MC), .LINE_OUT(LO), .LINE_COMPL_OUT(LC)
    );
    // ==========================================================
    // Tasks.
    // Compare one value and count the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One single transfer; each phase stands until ready is sampled high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge MCLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge MCLK); while (HREADY !== 1'b1);
        q = HRDATA;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    // Settings change only while stopped; reload, then start by command.
    task automatic run(input logic [31:0] c, input logic [15:0] p);
        wr(ctmc_pkg::ADDR_ENABLE, 32'h0);
        wr(ctmc_pkg::ADDR_CTRL, c);
        wr(ctmc_pkg::ADDR_PERIOD, {16'h0, p});
        wr(ctmc_pkg::ADDR_ENABLE, 32'h1);
        wr(ctmc_pkg::ADDR_CMD, 32'h1);
        wr(ctmc_pkg::ADDR_CMD, 32'h2);
    endtask : run
    // Cycles between two rises of terminal count, zero when fewer come.
    task automatic tc_gap(output int n);
        int r;
        int k;
        logic p;
        r = 0;
        n = 0;
        p = TC;
        for (k = 0; k < 400 && r < 2; k++) begin
            @(negedge MCLK);
            if (r == 1) n++;
            if (TC === 1'b1 && p !== 1'b1) r++;
            p = TC;
        end
        if (r < 2) n = 0;
    endtask : tc_gap
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // ==========================================================
    // Main sequence.
    initial begin
        ARST_N = 1'b0;
        HSEL = 1'b0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HADDR = 32'h0;
        HWDATA = 32'h0;
        HSIZE = 3'h2;
        TRIG_IN = 8'h00;
        repeat (16) @(posedge MCLK);
        ARST_N <= 1'b1;
        // Reset values, the 16-bit fields and an unmapped place.
        rd(ctmc_pkg::ADDR_CTRL, 32'h0);
        rd(ctmc_pkg::ADDR_PERIOD, 32'h0000ffff);
        rd(ctmc_pkg::ADDR_OACT, 32'h0000003f);
        rd(8'h3c, 32'h0);
        wr(ctmc_pkg::ADDR_COMPARE, 32'h1234abcd);
        rd(ctmc_pkg::ADDR_COMPARE, 32'h0000abcd);
        $display("test registers done");
        // Up and down space terminal counts alike; the two up/down codes differ.
        for (int d = 0; d < 4; d++) begin
            run(32'(d) << ctmc_pkg::DIR_LSB, 16'(A));
            tc_gap(g);
            chk(g, d < 2 ? A + 1 : (d == 2 ? 2 * A : A));
        end
        $display("test counting modes done");
        run(32'h1 << ctmc_pkg::PRESCALE_LSB, 16'(A));
        tc_gap(g);
        chk(g, 2 * (A + 1));
        run(32'h1 << ctmc_pkg::ONE_SHOT_BIT, 16'(A));
        tc_gap(g);
        chk(g, 0);
        rd(ctmc_pkg::ADDR_STATUS, 32'h0);
        // A stopped channel, and one in a non-counting mode, keep the count.
        wr(ctmc_pkg::ADDR_ENABLE, 32'h0);
        wr(ctmc_pkg::ADDR_COUNT, 32'h3);
        repeat (20) @(posedge MCLK);
        rd(ctmc_pkg::ADDR_COUNT, 32'h3);
        // Quadrature and the three waveform codes all hold the count.
        for (int m = 3; m < 7; m++) begin
            wr(ctmc_pkg::ADDR_ENABLE, 32'h0);
            wr(ctmc_pkg::ADDR_CTRL, 32'(m) << ctmc_pkg::MODE_LSB);
            wr(ctmc_pkg::ADDR_ENABLE, 32'h1);
            wr(ctmc_pkg::ADDR_CMD, 32'h2);
            repeat (20) @(posedge MCLK);
            rd(ctmc_pkg::ADDR_COUNT, 32'h3);
        end
        $display("test prescale one-shot hold done");
        // The buffer value lies past the period, so only one swap can occur.
        wr(ctmc_pkg::ADDR_ENABLE, 32'h0);
        wr(ctmc_pkg::ADDR_COMPARE, 32'h2);
        wr(ctmc_pkg::ADDR_CBUF, 32'hc);
        run(32'h1 << ctmc_pkg::SWAP_BIT, 16'h9);
        repeat (30) @(posedge MCLK);
        wr(ctmc_pkg::ADDR_ENABLE, 32'h0);
        rd(ctmc_pkg::ADDR_COMPARE, 32'hc);
        rd(ctmc_pkg::ADDR_CBUF, 32'h2);
        rd(ctmc_pkg::ADDR_IRQ, 32'h3);
        wr(ctmc_pkg::ADDR_IRQ_MASK, 32'h2);
        rd(ctmc_pkg::ADDR_IRQ_MASKED, 32'h2);
        wr(ctmc_pkg::ADDR_IRQ, 32'h1);
        rd(ctmc_pkg::ADDR_IRQ, 32'h2);
        $display("test compare swap done");
        // Count only on rising edges of trigger input 0.
        wr(ctmc_pkg::ADDR_ENABLE, 32'h0);
        wr(ctmc_pkg::ADDR_TSEL, 32'h1 << (ctmc_pkg::TRG_COUNT * ctmc_pkg::TSEL_W));
        run(32'h0, 16'h9);
        repeat (5) begin
            @(posedge MCLK);
            TRIG_IN <= 8'h01;
            repeat (4) @(posedge MCLK);
            TRIG_IN <= 8'h00;
            repeat (3) @(posedge MCLK);
        end
        repeat (8) @(posedge MCLK);
        rd(ctmc_pkg::ADDR_COUNT, 32'h5);
        $display("test count trigger done");
        // Overflow action set drives the line high.
        wr(ctmc_pkg::ADDR_ENABLE, 32'h0);
        wr(ctmc_pkg::ADDR_TSEL, 32'h0);
        wr(ctmc_pkg::ADDR_OACT, 32'h33);
        run(32'h0, 16'(A));
        tc_gap(g);
        repeat (2) @(negedge MCLK);
        chk({31'h0, LO}, 32'h1);
        chk({31'h0, LC}, 32'h0);
        $display("test line action done");
        wrap_up();
    end
    // The sequence needs about a thousand cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge MCLK);
        n_mismatch++;
        wrap_up();
    end
endmodule : ctmc_core_tb
`default_nettype wire
